// ==== rtl/sleep_power_pkg.sv ====
/*
 * constants for the sleep, power reduction and reset controller.
 * assumes an 8-bit i/o space reached by the cpu core, io address = data offset - 0x20.
 */
package sleep_power_pkg;
    localparam logic [7:0] io_data_base = 8'h20;
    localparam logic [7:0] sleep_mode_control_ofs = 8'h53;
    localparam logic [7:0] sleep_mode_control_io = 8'h33;
    localparam logic [7:0] power_reduction_control_ofs = 8'h64;
    localparam logic [7:0] sleep_mode_control_rst = 8'h00;
    localparam logic [7:0] power_reduction_control_rst = 8'h00;
    localparam int sleep_arm_bit = 0;
    localparam int sleep_mode_lsb = 1;
    localparam logic [2:0] mode_idle = 3'h0;
    localparam logic [2:0] mode_adc_noise = 3'h1;
    localparam logic [2:0] mode_power_down = 3'h2;
    localparam logic [2:0] mode_standby = 3'h6;
    localparam int can_stop_bit = 6;
    localparam int psc_stop_bit = 5;
    localparam int timer1_stop_bit = 4;
    localparam int timer0_stop_bit = 3;
    localparam int spi_stop_bit = 2;
    localparam int lin_stop_bit = 1;
    localparam int adc_stop_bit = 0;
    localparam logic [7:0] prr_used_mask = 8'h7f;
    localparam int wake_hold_cycles = 4;
    localparam int standby_wake_cycles = 6;
    localparam int clk_period_ns = 10;
    localparam int brownout_min_duration_ns = 2000;
    localparam int brownout_min_cycles = (brownout_min_duration_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int timeout_cnt_w = 20;
    typedef enum logic [3:0] {
        st_run = 4'b0001,
        st_sleep = 4'b0010,
        st_wake = 4'b0100,
        st_hold = 4'b1000
    } power_state_e;
endpackage : sleep_power_pkg

// ==== rtl/sleep_power_reset_control.sv ====
/*
 * sleep mode control, power reduction clock stops and reset combining with time-out stretch.
 * assumes the cpu core drives io_addr/io_wr/io_rd on core_clk, use_data_space selects the
 * data-space offset form; detector and pin inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module sleep_power_reset_control (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // io space access from the core
    input wire logic [7:0] io_addr,
    input wire logic use_data_space,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // core sleep handshake
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic [sleep_power_pkg::timeout_cnt_w-1:0] startup_cycles,
    output logic cpu_halt,
    output logic sleeping,
    output logic [2:0] active_mode,
    // clock and buffer control
    input wire logic debug_fuse,
    output logic clk_cpu_stop,
    output logic clk_io_stop,
    output logic clk_adc_stop,
    output logic osc_stop,
    output logic input_buf_disable,
    output logic wake_pin_enable,
    output logic can_clock_stop,
    output logic power_stage_clock_stop,
    output logic timer1_clock_stop,
    output logic timer0_clock_stop,
    output logic spi_clock_stop,
    output logic lin_clock_stop,
    output logic adc_clock_stop,
    output logic comparator_mux_block,
    // reset sources
    input wire logic supply_low,
    input wire logic ext_reset_pin_n,
    input wire logic external_reset_disable_fuse,
    input wire logic wdt_timeout,
    input wire logic wdt_reset_mode,
    input wire logic brownout_enable,
    input wire logic brownout_below,
    input wire logic [sleep_power_pkg::timeout_cnt_w-1:0] reset_timeout_period,
    // reset outputs
    output logic io_port_reset,
    output logic internal_reset
);
    import sleep_power_pkg::*;

    logic [7:0] sleep_mode_control_q, sleep_mode_control_d, prr_q, prr_d;
    power_state_e state_q, state_d;
    logic [timeout_cnt_w-1:0] wcnt_q, wcnt_d, tout_q, tout_d;
    logic [15:0] bcnt_q, bcnt_d;
    logic [1:0] por_s, pin_s, bod_s;
    logic wdt_pulse_q, brown_q, brown_d, int_rst_q, int_rst_d;

    // address decode: data offset or io address (offset - 0x20)
    wire [7:0] eff_addr = use_data_space ? io_addr : io_addr + io_data_base;
    wire sel_sleep_mode_control = eff_addr == sleep_mode_control_ofs;
    wire sel_prr = eff_addr == power_reduction_control_ofs;
    wire [2:0] mode_sel = sleep_mode_control_q[sleep_mode_lsb +: 3];
    wire mode_valid = mode_sel == mode_idle || mode_sel == mode_adc_noise ||
                      mode_sel == mode_power_down || mode_sel == mode_standby;
    wire sleep_go = sleep_exec && sleep_mode_control_q[sleep_arm_bit] && mode_valid;

    // registers, forced to reset values while the internal reset is active
    assign sleep_mode_control_d = (io_wr && sel_sleep_mode_control) ? {4'h0, io_wdata[3:0]} : sleep_mode_control_q;
    assign prr_d = (io_wr && sel_prr) ? (io_wdata & prr_used_mask) : prr_q;
    assign io_rdata = !io_rd ? 8'h00 : sel_sleep_mode_control ? sleep_mode_control_q : sel_prr ? prr_q : 8'h00;

    // sleep state machine
    always_comb begin
        state_d = state_q;
        wcnt_d = wcnt_q;
        case (state_q)
            st_run: begin
                if (sleep_go) begin
                    state_d = st_sleep;
                end
            end
            st_sleep: begin
                if (wake_irq) begin
                    state_d = st_wake;
                    wcnt_d = (active_mode == mode_standby) ?
                        timeout_cnt_w'(standby_wake_cycles - 1) : startup_cycles;
                end
            end
            st_wake: begin
                if (wcnt_q == '0) begin
                    state_d = st_hold;
                    wcnt_d = timeout_cnt_w'(wake_hold_cycles - 1);
                end else begin
                    wcnt_d = wcnt_q - 1'b1;
                end
            end
            st_hold: begin
                if (wcnt_q == '0) begin
                    state_d = st_run;
                end else begin
                    wcnt_d = wcnt_q - 1'b1;
                end
            end
            default: state_d = st_run;
        endcase
    end

    assign sleeping = state_q == st_sleep;
    assign cpu_halt = state_q != st_run;
    assign active_mode = mode_sel;
    wire deep = sleeping && (mode_sel == mode_power_down || mode_sel == mode_standby);
    assign clk_cpu_stop = sleeping;
    assign clk_io_stop = sleeping && mode_sel != mode_idle;
    assign clk_adc_stop = deep;
    assign osc_stop = sleeping && mode_sel == mode_power_down && !debug_fuse;
    assign input_buf_disable = clk_io_stop && clk_adc_stop;
    assign wake_pin_enable = 1'b1;

    // clock stops; timers simply lose their clock so their count holds
    assign can_clock_stop = prr_q[can_stop_bit];
    assign power_stage_clock_stop = prr_q[psc_stop_bit];
    assign lin_clock_stop = prr_q[lin_stop_bit];
    assign timer1_clock_stop = prr_q[timer1_stop_bit];
    assign timer0_clock_stop = prr_q[timer0_stop_bit];
    assign spi_clock_stop = prr_q[spi_stop_bit];
    assign adc_clock_stop = prr_q[adc_stop_bit];
    assign comparator_mux_block = prr_q[adc_stop_bit];

    // reset sources: clockless paths go straight to the port reset
    wire pin_active_raw = !ext_reset_pin_n && !external_reset_disable_fuse;
    wire bod_raw = brownout_enable && brownout_below;
    assign io_port_reset = supply_low || pin_active_raw || bod_raw || int_rst_q;
    wire pin_sync = pin_s[1];
    wire wdt_src = wdt_timeout && wdt_reset_mode;
    wire bod_long = bcnt_q >= 16'(brownout_min_cycles);
    assign brown_d = bod_s[1] && (brown_q || bod_long);
    assign bcnt_d = bod_s[1] ? (bod_long ? bcnt_q : bcnt_q + 16'h1) : 16'h0;
    wire any_src = por_s[1] || pin_sync || wdt_pulse_q || brown_q;
    assign tout_d = any_src ? reset_timeout_period : (tout_q != '0 ? tout_q - 1'b1 : tout_q);
    assign int_rst_d = any_src || tout_q != '0;
    assign internal_reset = int_rst_q || supply_low;

    always_ff @(posedge core_clk) begin
        por_s <= {por_s[0], supply_low};
        pin_s <= {pin_s[0], pin_active_raw};
        bod_s <= {bod_s[0], bod_raw};
        wdt_pulse_q <= wdt_src && !wdt_pulse_q;
        bcnt_q <= bcnt_d;
        brown_q <= brown_d;
        tout_q <= tout_d;
        int_rst_q <= int_rst_d;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || int_rst_q) begin
            sleep_mode_control_q <= sleep_mode_control_rst;
            prr_q <= power_reduction_control_rst;
            state_q <= st_run;
            wcnt_q <= '0;
        end else begin
            sleep_mode_control_q <= sleep_mode_control_d;
            prr_q <= prr_d;
            state_q <= state_d;
            wcnt_q <= wcnt_d;
        end
    end

    // assertions
    a_sleep_needs_arm: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(sleeping) |-> $past(sleep_mode_control_q[sleep_arm_bit] && sleep_exec))
        else $error("sleep entered without arm bit");
    a_reserved_no_sleep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == st_run && sleep_exec && !mode_valid) |=> !sleeping)
        else $error("reserved mode caused sleep");
    a_hold_four: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        $rose(state_q == st_hold) |-> (state_q == st_hold)[*4] ##1 state_q == st_run)
        else $error("wake hold not four cycles");
    a_standby_wake: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (sleeping && wake_irq && mode_sel == mode_standby) |-> ##7 state_q == st_hold)
        else $error("standby wake not six cycles");
    a_debug_osc: assert property (@(posedge core_clk) disable iff (!rst_n)
        debug_fuse |-> !osc_stop)
        else $error("oscillator stopped with debug fuse");
    a_buf_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sleeping && mode_sel == mode_power_down) |-> input_buf_disable && wake_pin_enable)
        else $error("input buffers not disabled in power-down");
    a_wdt_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        wdt_pulse_q |=> !wdt_pulse_q)
        else $error("watchdog pulse longer than one cycle");
    a_timeout_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($fell(any_src) && reset_timeout_period > 2) |=> int_rst_q ##1 int_rst_q)
        else $error("internal reset not stretched");
    a_prr_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr && io_wdata[can_stop_bit]) |=> can_clock_stop)
        else $error("can clock not stopped");

    // each stop bit follows the written value on the next edge
    a_psc_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr) |=> power_stage_clock_stop == $past(io_wdata[psc_stop_bit]))
        else $error("power stage clock stop wrong");
    a_lin_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr) |=> lin_clock_stop == $past(io_wdata[lin_stop_bit]))
        else $error("lin clock stop wrong");
    a_prr_top_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        prr_q[7] == 1'b0)
        else $error("unused stop bit set");
    a_tim1_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr) |=> timer1_clock_stop == $past(io_wdata[timer1_stop_bit]))
        else $error("timer1 clock stop wrong");
    a_tim0_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr) |=> timer0_clock_stop == $past(io_wdata[timer0_stop_bit]))
        else $error("timer0 clock stop wrong");
    a_timer_freeze: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        !(io_wr && sel_prr) |=> $stable(timer0_clock_stop) && $stable(timer1_clock_stop))
        else $error("timer stop changed without write");
    a_spi_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr) |=> spi_clock_stop == $past(io_wdata[spi_stop_bit]))
        else $error("spi clock stop wrong");
    a_adc_write: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (io_wr && sel_prr) |=> adc_clock_stop == $past(io_wdata[adc_stop_bit]))
        else $error("adc clock stop wrong");
    a_comp_mux: assert property (@(posedge core_clk) disable iff (!rst_n)
        adc_clock_stop |-> comparator_mux_block)
        else $error("comparator mux free while adc shut");

    // sleep decode and wake sequencing
    a_io_alias: assert property (@(posedge core_clk) disable iff (!rst_n)
        (io_rd && !use_data_space && io_addr == sleep_mode_control_io) |-> io_rdata == sleep_mode_control_q)
        else $error("io alias of sleep control wrong");
    a_sleep_mode_control_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        sleep_mode_control_q[7:4] == 4'h0)
        else $error("sleep control upper bits set");
    a_idle_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sleeping && active_mode == mode_idle) |-> clk_cpu_stop && !clk_io_stop && !clk_adc_stop)
        else $error("idle clock gating wrong");
    a_no_arm: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (state_q == st_run && sleep_exec && !sleep_mode_control_q[sleep_arm_bit]) |=> !sleeping)
        else $error("sleep without arm");
    a_reserved_run: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (state_q == st_run && !mode_valid) |=> state_q == st_run)
        else $error("reserved mode left run");
    a_stay_asleep: assert property (@(posedge core_clk) disable iff (!rst_n || int_rst_q)
        (state_q == st_sleep && !wake_irq) |=> state_q == st_sleep)
        else $error("woke without interrupt");
    a_run_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        !sleeping |-> !clk_cpu_stop && !input_buf_disable && !osc_stop)
        else $error("clock stopped while running");
    a_wake_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
        input_buf_disable |-> wake_pin_enable)
        else $error("wake pins disabled");
    a_standby_osc: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sleeping && mode_sel == mode_standby) |-> !osc_stop)
        else $error("oscillator stopped in standby");

    // reset combining
    a_reset_clears: assert property (@(posedge core_clk)
        int_rst_q |=> sleep_mode_control_q == sleep_mode_control_rst && prr_q == power_reduction_control_rst && !cpu_halt)
        else $error("registers not cleared by reset");
    a_port_async: assert property (@(posedge core_clk)
        (supply_low || (!ext_reset_pin_n && !external_reset_disable_fuse)) |-> io_port_reset)
        else $error("port reset missing");
    a_sources_or: assert property (@(posedge core_clk)
        (por_s[1] || pin_s[1] || wdt_pulse_q || brown_q) |=> int_rst_q)
        else $error("reset source not combined");
    a_por_now: assert property (@(posedge core_clk)
        supply_low |-> internal_reset)
        else $error("power-on reset delayed");
    a_pin_fuse: assert property (@(posedge core_clk)
        $past(external_reset_disable_fuse, 2) |-> !pin_s[1])
        else $error("disabled pin reset acted");
    a_brown_stretch: assert property (@(posedge core_clk)
        $fell(brown_q) |-> int_rst_q)
        else $error("brown-out release not stretched");
    a_brown_short: assert property (@(posedge core_clk)
        (bod_s[1] && !brown_q && !bod_long) |=> !brown_q)
        else $error("short dip caused brown-out");
    a_wdt_mode: assert property (@(posedge core_clk)
        !wdt_reset_mode |=> !wdt_pulse_q)
        else $error("watchdog reset outside reset mode");
    a_wdt_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($fell(wdt_pulse_q) && $stable(reset_timeout_period)) |-> tout_q == reset_timeout_period)
        else $error("time-out not started at pulse fall");
endmodule : sleep_power_reset_control
`default_nettype wire

// ==== bench/sleep_power_reset_control_tb.sv ====
/* self-checking bench for sleep_power_reset_control: registers, sleep entry and wake, reset sources.
   assumes sleep_power_pkg is compiled first; inputs are driven at the falling edge of core_clk. */
`timescale 1ns/1ps
`default_nettype none
module sleep_power_reset_control_tb;
    import sleep_power_pkg::*;
    logic core_clk, rst_n, use_data_space, io_wr, io_rd, sleep_exec, wake_irq, debug_fuse, supply_low;
    logic ext_reset_pin_n, external_reset_disable_fuse, wdt_timeout, wdt_reset_mode, brownout_enable;
    logic brownout_below, cpu_halt, sleeping, clk_cpu_stop, clk_io_stop, clk_adc_stop, osc_stop;
    logic input_buf_disable, wake_pin_enable, comparator_mux_block, io_port_reset, internal_reset;
    logic [7:0] io_addr, io_wdata, io_rdata;
    logic [timeout_cnt_w-1:0] startup_cycles, reset_timeout_period;
    logic [2:0] active_mode;
    logic [6:0] stops;
    int err_total, n_compared;
    // short stretch keeps every reset scenario brief
    localparam int tout = 16;
    sleep_power_reset_control DUT (.*, .can_clock_stop(stops[6]), .power_stage_clock_stop(stops[5]),
        .timer1_clock_stop(stops[4]), .timer0_clock_stop(stops[3]), .spi_clock_stop(stops[2]),
        .lin_clock_stop(stops[1]), .adc_clock_stop(stops[0]));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    task automatic wr(input logic ds, input logic [7:0] a, input logic [7:0] d);
        io_addr = a;
        use_data_space = ds;
        io_wdata = d;
        io_wr = 1'b1;
        cyc(1);
        io_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic ds, input logic [7:0] a, input logic [7:0] e);
        io_addr = a;
        use_data_space = ds;
        io_rd = 1'b1;
        #2;
        chk(io_rdata, e);
        cyc(1);
        io_rd = 1'b0;
        cyc(1);
    endtask : rd
    // waits for the stretched reset to end; the count starts when the source is released
    task automatic settle(input int lo);
        int c;
        c = 0;
        while (internal_reset !== 1'b0 && c < 3000) begin
            cyc(1);
            c++;
        end
        chk({7'h0, c >= lo && c < 3000}, 8'h01);
        if (c >= 3000) summarize();
    endtask : settle
    task automatic slp(input logic [2:0] m, input logic arm, input logic e);
        int c;
        logic deep;
        deep = (m == mode_power_down) || (m == mode_standby);
        wr(1'b0, 8'h33, {4'h0, m, arm});
        sleep_exec = 1'b1;
        cyc(1);
        sleep_exec = 1'b0;
        chk({7'h0, sleeping}, {7'h0, e});
        if (e) begin
            chk({5'h0, active_mode}, {5'h0, m});
            chk({2'h0, input_buf_disable, wake_pin_enable, clk_cpu_stop, clk_io_stop, clk_adc_stop, osc_stop},
                {2'h0, deep, 1'b1, 1'b1, m != mode_idle, deep, m == mode_power_down && !debug_fuse});
            wake_irq = 1'b1;
            c = 0;
            while (cpu_halt === 1'b1 && c < 200) begin
                cyc(1);
                c++;
            end
            wake_irq = 1'b0;
            chk({7'h0, c >= wake_hold_cycles && c < 200}, 8'h01);
            if (c >= 200) summarize();
            if (m == mode_standby) chk({7'h0, c <= standby_wake_cycles + wake_hold_cycles + 1}, 8'h01);
        end
        wr(1'b0, 8'h33, 8'h00);
    endtask : slp
    initial begin
        {use_data_space, io_wr, io_rd, sleep_exec, wake_irq, debug_fuse, wdt_timeout, wdt_reset_mode} = 8'h00;
        {external_reset_disable_fuse, brownout_enable, brownout_below} = 3'h0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        ext_reset_pin_n = 1'b1;
        startup_cycles = 20'h3;
        reset_timeout_period = 20'h10;
        err_total = 0;
        n_compared = 0;
        rst_n = 1'b0;
        supply_low = 1'b1;
        cyc(12);
        rst_n = 1'b1;
        supply_low = 1'b0;
        settle(tout);
        rd(1'b1, 8'h53, 8'h00);
        rd(1'b0, 8'h44, 8'h00);
        wr(1'b1, 8'h53, 8'hff);
        rd(1'b0, 8'h33, 8'h0f);
        rd(1'b0, 8'h35, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(1'b1, 8'h64, 8'h01 << i);
            chk({1'b0, stops}, 8'h01 << i);
            chk({7'h0, comparator_mux_block}, {7'h0, i == 0});
        end
        wr(1'b1, 8'h64, 8'hff);
        rd(1'b1, 8'h64, 8'h7f);
        $display("registers done");
        wr(1'b0, 8'h33, 8'h00);
        slp(mode_power_down, 1'b0, 1'b0);
        for (int m = 0; m < 8; m++) begin
            slp(m[2:0], 1'b1, m == 0 || m == 1 || m == 2 || m == 6);
        end
        wr(1'b1, 8'h64, 8'h00);
        debug_fuse = 1'b1;
        slp(mode_power_down, 1'b1, 1'b1);
        debug_fuse = 1'b0;
        $display("sleep done");
        ext_reset_pin_n = 1'b0;
        #1;
        chk({7'h0, io_port_reset}, 8'h01);
        cyc(5);
        chk({7'h0, internal_reset}, 8'h01);
        ext_reset_pin_n = 1'b1;
        settle(tout);
        wr(1'b1, 8'h64, 8'h7f);
        ext_reset_pin_n = 1'b0;
        cyc(5);
        ext_reset_pin_n = 1'b1;
        settle(tout);
        rd(1'b1, 8'h64, 8'h00);
        external_reset_disable_fuse = 1'b1;
        ext_reset_pin_n = 1'b0;
        cyc(10);
        chk({7'h0, internal_reset}, 8'h00);
        ext_reset_pin_n = 1'b1;
        external_reset_disable_fuse = 1'b0;
        for (int k = 0; k < 2; k++) begin
            wdt_reset_mode = k[0];
            wdt_timeout = 1'b1;
            cyc(1);
            wdt_timeout = 1'b0;
            cyc(4);
            chk({7'h0, internal_reset}, {7'h0, k[0]});
            if (k == 1) settle(tout - 4);
        end
        brownout_enable = 1'b1;
        brownout_below = 1'b1;
        cyc(brownout_min_cycles / 4);
        brownout_below = 1'b0;
        cyc(5);
        chk({7'h0, internal_reset}, 8'h00);
        brownout_below = 1'b1;
        cyc(brownout_min_cycles + 10);
        chk({7'h0, internal_reset}, 8'h01);
        brownout_below = 1'b0;
        settle(tout);
        supply_low = 1'b1;
        #1;
        chk({6'h0, internal_reset, io_port_reset}, 8'h03);
        cyc(3);
        supply_low = 1'b0;
        settle(tout);
        $display("resets done");
        summarize();
    end
endmodule : sleep_power_reset_control_tb
`default_nettype wire
